/* File: rtl/gate_driver_params.svh */
// Timing counts and reset values for the gate driver control logic.
// Assumes one sampling clock at 250 MHz (4 ns period).
`ifndef GATE_DRIVER_PARAMS_SVH
`define GATE_DRIVER_PARAMS_SVH

`define GD_CLK_PERIOD_NS    4
`define GD_DEGLITCH_NS      40
`define GD_RST_FILTER_NS    1000
`define GD_FAULT_MUTE_NS    1000

// Least times, rounded up to whole cycles
`define GD_DEGLITCH_CYC     ((`GD_DEGLITCH_NS + `GD_CLK_PERIOD_NS - 1) / `GD_CLK_PERIOD_NS)
`define GD_RST_FILTER_CYC   ((`GD_RST_FILTER_NS + `GD_CLK_PERIOD_NS - 1) / `GD_CLK_PERIOD_NS)
`define GD_FAULT_MUTE_CYC   ((`GD_FAULT_MUTE_NS + `GD_CLK_PERIOD_NS - 1) / `GD_CLK_PERIOD_NS)

// Sampled-pin and output reset values
`define GD_PIN_RST          1'h0
`define GD_SUPPLY_UNDERVOLTAGE_LOCKOUT_PIN_RST     1'h1
`define GD_OE_N_RST         1'h1
`define GD_CLAMP_RST        1'h1

`endif

/* File: rtl/gate_driver_pkg.sv */
// Types shared by the gate driver control logic.
// Assumes gate_driver_params.svh supplies the numeric constants.
`default_nettype none

package gate_driver_pkg;

	typedef enum logic [1:0] {
		ST_NORMAL  = 2'h0,
		ST_MUTE    = 2'h1,
		ST_LATCHED = 2'h2
	} fault_state_t;

	typedef struct packed {
		logic on;
		logic normal_off;
		logic soft_off;
	} gate_drive_t;

	typedef struct packed {
		logic in_pos;
		logic in_neg;
		logic rst_en_n;
		logic oc;
		logic supply_undervoltage_lockout;
		logic force_on;
	} pin_levels_t;

endpackage : gate_driver_pkg

`default_nettype wire

/* File: rtl/pin_deglitch.sv */
// Three-stage pin synchroniser followed by a minimum-width pulse filter.
// Assumes the pin is asynchronous to mclk_in.
`default_nettype none

module pin_deglitch #(
	parameter int   FILTER_CYCLES = 10,
	parameter logic RESET_LEVEL   = 1'h0
) (
	input  wire logic mclk_in,   // Sampling clock
	input  wire logic rst_in,    // Synchronous reset, active high
	input  wire logic pin_in,    // Raw pin level
	output var  logic level_out  // Filtered level
);

	localparam int CW = $clog2(FILTER_CYCLES + 1);

	logic          s1_r;
	logic          s2_r;
	logic          s3_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          differs;
	logic          settle;

	// Stages two and three must agree before a change counts
	assign differs = (s2_r == s3_r) && (s3_r != level_out);
	assign settle  = differs && (cnt_r == CW'(FILTER_CYCLES - 1));
	assign cnt_nxt = differs ? cnt_r + CW'(1) : '0;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			s1_r      <= RESET_LEVEL;
			s2_r      <= RESET_LEVEL;
			s3_r      <= RESET_LEVEL;
			cnt_r     <= '0;
			level_out <= RESET_LEVEL;
		end else begin
			s1_r  <= pin_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			cnt_r <= settle ? '0 : cnt_nxt;
			if (settle) begin
				level_out <= s3_r;
			end
		end
	end

endmodule : pin_deglitch

`default_nettype wire

/* File: rtl/gate_driver_control_logic.sv */
// Control logic of an isolated single-channel gate driver.
// Assumes all pins are asynchronous to mclk_in; open-drain pins are
// resolved outside from the output and its active-low enable.
`include "gate_driver_params.svh"
`default_nettype none

module gate_driver_control_logic
	import gate_driver_pkg::*;
#(
	parameter int DEGLITCH_CYCLES   = `GD_DEGLITCH_CYC,
	parameter int RST_FILTER_CYCLES = `GD_RST_FILTER_CYC,
	parameter int FAULT_MUTE_CYCLES = `GD_FAULT_MUTE_CYC
) (
	input  wire logic  mclk_in,                        // 250 MHz sampling clock
	input  wire logic  rst_in,                         // Synchronous reset, active high
	input  wire logic  in_pos_in,                      // Noninverting PWM input
	input  wire logic  in_neg_in,                      // Inverting PWM input
	input  wire logic  reset_enable_n_in,              // Reset / enable, low disables
	input  wire logic  overcurrent_sense_in,           // Overcurrent comparator, high = fault
	input  wire logic  supply_undervoltage_lockout_in, // Output supply in lockout, high
	input  wire logic  force_on_request_in,            // Active short circuit request
	output var  gate_drive_t gate_output_out,          // Pull-up / normal / soft pull-down
	output var  logic  clamp_drive_out,                // External Miller clamp FET on
	output var  logic  fault_n_out,                    // Open-drain fault level (low)
	output var  logic  fault_n_oe_n_out,               // Low while fault_n pulled down
	output var  logic  power_good_out,                 // Open-drain power good level (low)
	output var  logic  power_good_oe_n_out             // Low while power good pulled down
);

	localparam int NPINS = 6;
	localparam int MW    = $clog2(FAULT_MUTE_CYCLES + 1);
	localparam int RW    = $clog2(RST_FILTER_CYCLES + 1);

	logic [NPINS-1:0] raw_pins;
	logic [NPINS-1:0] filt_pins;
	pin_levels_t      pins;

	fault_state_t     state_r;
	fault_state_t     state_nxt;
	logic [MW-1:0]    mute_cnt_r;
	logic [MW-1:0]    mute_cnt_nxt;
	logic [RW-1:0]    low_cnt_r;
	logic [RW-1:0]    low_cnt_nxt;
	logic             en_prev_r;
	gate_drive_t      drive_nxt;

	logic             enabled;
	logic             en_rise;
	logic             reset_qualified;
	logic             fault_clear;
	logic             oc_trip;
	logic             mute_done;
	logic             faulted;
	logic             forced;
	logic             pwm_on;
	logic             drive_on;

	// Pin order matches pin_levels_t from the top bit down
	assign raw_pins = {in_pos_in, in_neg_in, reset_enable_n_in,
		overcurrent_sense_in, supply_undervoltage_lockout_in, force_on_request_in};
	assign pins     = pin_levels_t'(filt_pins);

	// PWM and reset/enable get the full deglitch; the rest only synchronise
	generate
		for (genvar i = 0; i < NPINS; i++) begin : g_pin
			localparam bit LONG = (i >= 3);
			pin_deglitch #(
				.FILTER_CYCLES (LONG ? DEGLITCH_CYCLES : 1),
				.RESET_LEVEL   ((i == 1) ? `GD_SUPPLY_UNDERVOLTAGE_LOCKOUT_PIN_RST : `GD_PIN_RST)
			) u_filt (
				.mclk_in   (mclk_in),
				.rst_in    (rst_in),
				.pin_in    (raw_pins[i]),
				.level_out (filt_pins[i])
			);
		end
	endgenerate

	assign enabled   = pins.rst_en_n;
	assign en_rise   = enabled && !en_prev_r;
	assign forced    = pins.force_on && !pins.supply_undervoltage_lockout;

	// Overcurrent is only sensed while the gate is being driven on
	assign oc_trip   = pins.oc && gate_output_out.on;
	assign mute_done = (mute_cnt_r == MW'(FAULT_MUTE_CYCLES - 1));

	// Low time counts only once mute is over, so earlier lows are ignored
	assign low_cnt_nxt = (state_r != ST_LATCHED) ? '0 :
		enabled ? '0 :
		reset_qualified ? low_cnt_r : low_cnt_r + RW'(1);
	assign reset_qualified = (low_cnt_r == RW'(RST_FILTER_CYCLES));
	assign fault_clear = (state_r == ST_LATCHED) && en_rise && reset_qualified;

	assign mute_cnt_nxt = (state_r == ST_MUTE) ? mute_cnt_r + MW'(1) : '0;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_NORMAL: begin
				if (oc_trip) begin
					state_nxt = ST_MUTE;
				end
			end
			ST_MUTE: begin
				if (mute_done) begin
					state_nxt = ST_LATCHED;
				end
			end
			ST_LATCHED: begin
				if (fault_clear) begin
					state_nxt = ST_NORMAL;
				end
			end
			default: begin
				state_nxt = ST_LATCHED;
			end
		endcase
	end

	assign faulted  = (state_nxt != ST_NORMAL);

	// Interlock: both PWM inputs high gives a low output
	assign pwm_on   = pins.in_pos && !pins.in_neg;

	// Priority: lockout, forced on, fault, disable, PWM
	assign drive_on = pins.supply_undervoltage_lockout ? 1'b0 :
		forced ? 1'b1 :
		faulted ? 1'b0 :
		!enabled ? 1'b0 :
		pwm_on;

	assign drive_nxt.on         = drive_on;
	assign drive_nxt.soft_off   = !drive_on && faulted && !pins.supply_undervoltage_lockout;
	assign drive_nxt.normal_off = !drive_on && !drive_nxt.soft_off;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_r    <= ST_NORMAL;
			mute_cnt_r <= '0;
			low_cnt_r  <= '0;
			en_prev_r  <= `GD_PIN_RST;
		end else begin
			state_r    <= state_nxt;
			mute_cnt_r <= mute_cnt_nxt;
			low_cnt_r  <= low_cnt_nxt;
			en_prev_r  <= enabled;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			gate_output_out     <= '{on: 1'b0, normal_off: 1'b1, soft_off: 1'b0};
			clamp_drive_out     <= `GD_CLAMP_RST;
			fault_n_out         <= 1'h0;
			fault_n_oe_n_out    <= `GD_OE_N_RST;
			power_good_out      <= 1'h0;
			power_good_oe_n_out <= 1'h0;
		end else begin
			gate_output_out     <= drive_nxt;
			clamp_drive_out     <= !drive_on;
			fault_n_out         <= 1'h0;
			fault_n_oe_n_out    <= !faulted;
			power_good_out      <= 1'h0;
			power_good_oe_n_out <= !pins.supply_undervoltage_lockout;
		end
	end

endmodule : gate_driver_control_logic

`default_nettype wire

/* File: dv/pwm_host.sv */
// Controller model that drives the PWM and reset/enable pins.
// Assumes commands from the bench, taken on the bench clock.
`default_nettype none
module pwm_host (
	input  wire logic clk_in,   // Bench clock
	input  wire logic top_in,   // Own switch PWM
	input  wire logic bot_in,   // Opposite switch PWM
	input  wire logic neg_in,   // Interlock wired
	input  wire logic en_in,    // Enable level
	output var  logic pos_out,  // Noninverting pin
	output var  logic inv_out,  // Inverting pin
	output var  logic en_n_out  // Reset/enable pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pins never float, low until the first command lands
	initial {pos_out, inv_out, en_n_out} = 3'h0;
	always @(posedge clk_in) begin
		pos_out  <= top_in;
		inv_out  <= neg_in & bot_in;
		en_n_out <= en_in;
	end
endmodule : pwm_host
`default_nettype wire

/* File: dv/gate_driver_asserts.sv */
// Assertions on the gate driver control logic pins.
// Assumes the pins change only at the sampling clock of the block.
`default_nettype none
module gate_driver_asserts
	import gate_driver_pkg::*;
(
	input wire logic        mclk_in, // Clock
	input wire logic        rst_in, // Reset
	input wire logic        in_pos_in, // PWM
	input wire logic        in_neg_in, // PWM
	input wire logic        reset_enable_n_in, // Enable
	input wire logic        supply_undervoltage_lockout_in, // Lockout
	input wire logic        force_on_request_in, // Force
	input wire gate_drive_t gate_output_out, // Gate
	input wire logic        clamp_drive_out, // Clamp
	input wire logic        fault_n_oe_n_out, // Fault
	input wire logic        power_good_oe_n_out // Power good
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	wire logic lock_w = in_neg_in && !force_on_request_in;
	wire logic asc_w  = force_on_request_in && !supply_undervoltage_lockout_in;
	chk_clamp_follow: assert property (clamp_drive_out == !gate_output_out.on)
		else $error("clamp wrong");
	chk_interlock_off: assert property (
		lock_w [*8] ##1 lock_w [*8] |-> !gate_output_out.on) else $error("interlock");
	chk_rise_cause: assert property (
		$rose(gate_output_out.on) && !force_on_request_in
		|-> $past(in_pos_in, 6) && $past(in_pos_in, 12)) else $error("short pulse passed");
	chk_fault_cause: assert property ($fell(fault_n_oe_n_out)
		|-> $past(gate_output_out.on)) else $error("fault while off");
	chk_fault_soft: assert property ($fell(fault_n_oe_n_out) && !force_on_request_in
		|-> gate_output_out.soft_off || !power_good_oe_n_out) else $error("no soft off");
	chk_clear_low: assert property ($rose(fault_n_oe_n_out)
		|-> !$past(reset_enable_n_in, 20)) else $error("fault cleared early");
	chk_lockout_off: assert property (supply_undervoltage_lockout_in [*8]
		|-> gate_output_out.normal_off && !power_good_oe_n_out) else $error("lockout");
	chk_force_on: assert property (asc_w [*8] |-> gate_output_out.on)
		else $error("force ignored");
endmodule : gate_driver_asserts

bind gate_driver_control_logic gate_driver_asserts gate_driver_asserts_i (.*);
`default_nettype wire

/* File: dv/gate_driver_control_logic_bench.sv */
// Self-checking bench: PWM, enable, fault, lockout and force traffic.
// Assumes the controller model and the bound checker are compiled first.
`default_nettype none
module gate_driver_control_logic_bench import gate_driver_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, ip, inn, enn, top, bot, neg, en, oc, supply_undervoltage_lockout, frc, clamp, fo, pgo;
	logic [2:0]  v;
	gate_drive_t g;
	int          error_cnt, total_checks;
	wire logic [5:0] st = {g, clamp, fo, pgo};
	gate_driver_control_logic #(.RST_FILTER_CYCLES(4), .FAULT_MUTE_CYCLES(60))
		gate_driver_control_logic_i (.mclk_in(clk), .rst_in(rst), .in_pos_in(ip),
		.in_neg_in(inn), .reset_enable_n_in(enn), .overcurrent_sense_in(oc),
		.supply_undervoltage_lockout_in(supply_undervoltage_lockout), .force_on_request_in(frc),
		.gate_output_out(g), .clamp_drive_out(clamp), .fault_n_out(),
		.fault_n_oe_n_out(fo), .power_good_out(), .power_good_oe_n_out(pgo));
	pwm_host pwm_host_i (.clk_in(clk), .top_in(top), .bot_in(bot), .neg_in(neg),
		.en_in(en), .pos_out(ip), .inv_out(inn), .en_n_out(enn));
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	function automatic logic [5:0] pwm_exp(input logic [2:0] c);
		return (c[2] & !(c[1] & c[0])) ? 6'h23 : 6'h17;
	endfunction : pwm_exp
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	// Drives {rst,top,bot,neg,en,oc,supply_undervoltage_lockout,frc}; then awaits e, or with h demands it n cycles
	task automatic go(input logic [7:0] p, input logic [5:0] e, input int n, input bit h);
		@(posedge clk);
		{rst, top, bot, neg, en, oc, supply_undervoltage_lockout, frc} <= p;
		total_checks++;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			if (!h && st === e) return;
			if (h && st !== e) break;
		end
		if (h && st === e) return;
		error_cnt++;
		$display("CHECK FAILED %0t exp %h got %h", $time, e, st);
	endtask : go
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		final_report();
	end
	initial begin
		{rst, top, bot, neg, en, oc, supply_undervoltage_lockout, frc} = 8'h8A;
		void'($urandom(32'hEF93));
		repeat (18) @(posedge clk);
		go(8'h8A, 6'h16, 1, 1);
		go(8'h08, 6'h17, 20, 0);
		for (int i = 0; i < 24; i++) begin
			v = (i < 8) ? i[2:0] : 3'($urandom);
			go({1'h0, v, 4'h8}, pwm_exp(v), 40, 0);
			go({1'h0, v, 4'h8}, pwm_exp(v), 20, 1);
		end
		go(8'h08, 6'h17, 40, 0);
		go(8'h48, 6'h17, 8, 1);
		go(8'h08, 6'h17, 30, 1);
		go(8'h00, 6'h17, 20, 1);
		go(8'h40, 6'h17, 30, 1);
		go(8'h48, 6'h23, 40, 0);
		go(8'h4C, 6'h0D, 20, 0);
		go(8'h48, 6'h0D, 40, 1);
		go(8'h40, 6'h0D, 20, 1);
		go(8'h48, 6'h23, 40, 0);
		go(8'h4C, 6'h0D, 20, 0);
		go(8'h44, 6'h0D, 12, 1);
		go(8'h48, 6'h0D, 20, 1);
		go(8'h40, 6'h0D, 70, 1);
		go(8'h48, 6'h23, 40, 0);
		go(8'h08, 6'h17, 40, 0);
		go(8'h09, 6'h23, 20, 0);
		go(8'h01, 6'h23, 40, 1);
		go(8'h03, 6'h16, 20, 0);
		go(8'h08, 6'h17, 30, 0);
		final_report();
	end
endmodule : gate_driver_control_logic_bench
`default_nettype wire
